// >>> src/mosc_top.sv
/*
  Milliampere output scaling control: Avalon-MM register slave, per-channel
  settings and a round-robin sequencer that maps each channel's measured
  quantity onto an output current code for the option-card drivers.
  Assumes measurement values arrive on clk_sys_i in thousandths.
*/
// Local design decisions: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ns
// What this block does
// - Two option cards, each its own group
// - Four outputs per card, one input
// - Card one pairs channels 1-2, 3-4
// - Card two pairs channels 5-6, 7-8
// - Pair enables reset off and gate outputs
// - Channel enable, off by default, hides curve settings
// - Five categories, currents by default
// - Quantity chosen only within its category
// - Input point one, signed thousandths, default zero
// - Input point two, same range, default one
// - At or below point one: output one
// - At or above point two: output two
module mosc_top
  import mosc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [DATA_W-1:0] avs_writedata_i,
  output logic [DATA_W-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [NUM_SRC-1:0][VAL_W-1:0] meas_val_i,
  output logic [NUM_CH-1:0][CODE_W-1:0] ma_code_o,
  output logic [NUM_CH-1:0] ma_active_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic ack_q, ack_d;
  logic [DATA_W-1:0] rdata_q, rdata_d, rmux;
  logic [NUM_PAIRS-1:0] pair_en_q, pair_en_d;
  logic req, wr_take;
  logic [CH_W-1:0] bus_ch;
  logic [2:0] bus_reg;
  logic [NUM_CH-1:0] cfg_wr;

  logic [NUM_CH-1:0] ch_en;
  logic [2:0] ch_cat [NUM_CH];
  logic [QTY_W-1:0] ch_qty [NUM_CH];
  logic signed [VAL_W-1:0] ch_in1 [NUM_CH];
  logic signed [VAL_W-1:0] ch_in2 [NUM_CH];
  logic [CODE_W-1:0] ch_out1 [NUM_CH];
  logic [CODE_W-1:0] ch_out2 [NUM_CH];

  mosc_seq_t seq_q, seq_d;
  logic [CH_W-1:0] idx_q, idx_d;
  logic [NUM_CH-1:0][CODE_W-1:0] code_q, code_d;
  logic [NUM_CH-1:0] active_q, active_d;

  logic [SEL_W-1:0] sel;
  logic signed [VAL_W-1:0] x, in1, in2;
  logic signed [VAL_W:0] dx, den;
  logic [CODE_W:0] dout, ndout;
  logic [CODE_W-1:0] mag;
  logic neg, live;
  logic [NUM_W-1:0] num, quot;
  logic div_start, div_done;

  // ----------------------------------------------------------------
  // Avalon-MM slave: one wait state, answer on the second cycle
  // ----------------------------------------------------------------
  assign req = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~ack_q;
  assign wr_take = avs_write_i & ack_q;
  assign bus_ch = avs_address_i[CH_IDX_LSB +: CH_W];
  assign bus_reg = avs_address_i[REG_IDX_LSB +: 3];

  always_comb
  begin
    rmux = '0;
    if (avs_address_i[CH_SPACE_BIT])
    begin
      unique case (bus_reg)
        ROFF_CFG:
        begin
          rmux[CFG_EN_BIT] = ch_en[bus_ch];
          rmux[CFG_CAT_LSB +: 3] = ch_cat[bus_ch];
          rmux[CFG_QTY_LSB +: QTY_W] = ch_qty[bus_ch];
        end
        // Curve settings read as zero while the channel is off
        ROFF_IN1_LO: rmux = ch_en[bus_ch] ? ch_in1[bus_ch][DATA_W-1:0] : '0;
        ROFF_IN1_HI: rmux[HI_W-1:0] = ch_en[bus_ch] ? ch_in1[bus_ch][VAL_W-1:DATA_W] : '0;
        ROFF_OUT1: rmux[CODE_W-1:0] = ch_en[bus_ch] ? ch_out1[bus_ch] : '0;
        ROFF_IN2_LO: rmux = ch_en[bus_ch] ? ch_in2[bus_ch][DATA_W-1:0] : '0;
        ROFF_IN2_HI: rmux[HI_W-1:0] = ch_en[bus_ch] ? ch_in2[bus_ch][VAL_W-1:DATA_W] : '0;
        ROFF_OUT2: rmux[CODE_W-1:0] = ch_en[bus_ch] ? ch_out2[bus_ch] : '0;
        ROFF_NOW: rmux[CODE_W-1:0] = code_q[bus_ch];
      endcase
    end
    else if (avs_address_i == OFF_PAIR_EN)
    begin
      rmux[NUM_PAIRS-1:0] = pair_en_q;
    end
    else if (avs_address_i == OFF_STATUS)
    begin
      rmux[NUM_CH-1:0] = active_q;
      rmux[STAT_BUSY_BIT] = (seq_q == SEQ_DIV);
    end
  end

  always_comb
  begin
    ack_d = req & ~ack_q;
    rdata_d = ack_d ? rmux : rdata_q;
    pair_en_d = pair_en_q;
    if (wr_take && avs_address_i == OFF_PAIR_EN)
    begin
      pair_en_d = avs_writedata_i[NUM_PAIRS-1:0];
    end
    for (int i = 0; i < NUM_CH; i++)
    begin
      cfg_wr[i] = wr_take & avs_address_i[CH_SPACE_BIT] & (bus_ch == CH_W'(i));
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ack_q <= 1'b0;
      rdata_q <= '0;
      pair_en_q <= PAIR_EN_RST;
    end
    else
    begin
      ack_q <= ack_d;
      rdata_q <= rdata_d;
      pair_en_q <= pair_en_d;
    end
  end

  assign avs_readdata_o = rdata_q;

  // ----------------------------------------------------------------
  // Channel settings, cards laid out as consecutive groups of four
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NUM_CH; g++)
  begin : g_ch
    mosc_chan_cfg u_cfg (
      .clk_sys_i(clk_sys_i),
      .nrst_i(nrst_i),
      .wr_i(cfg_wr[g]),
      .reg_i(bus_reg),
      .wdata_i(avs_writedata_i),
      .en_o(ch_en[g]),
      .cat_o(ch_cat[g]),
      .qty_o(ch_qty[g]),
      .in1_o(ch_in1[g]),
      .in2_o(ch_in2[g]),
      .out1_o(ch_out1[g]),
      .out2_o(ch_out2[g])
    );
  end

  // ----------------------------------------------------------------
  // Scaling datapath for the channel under evaluation
  // ----------------------------------------------------------------
  always_comb
  begin
    sel = {ch_cat[idx_q], ch_qty[idx_q]};
    x = meas_val_i[sel];
    // Raw 36-bit settings are clamped here, so a half-written value stays within +/-IN_MAX
    in1 = mosc_sat_in(ch_in1[idx_q]);
    in2 = mosc_sat_in(ch_in2[idx_q]);
    // Pair index is channel over two; card is the top index bit
    live = ch_en[idx_q] & pair_en_q[idx_q[CH_W-1:1]];
    dx = {x[VAL_W-1], x} - {in1[VAL_W-1], in1};
    den = {in2[VAL_W-1], in2} - {in1[VAL_W-1], in1};
    dout = {1'b0, ch_out2[idx_q]} - {1'b0, ch_out1[idx_q]};
    ndout = -dout;
    neg = dout[CODE_W];
    mag = neg ? ndout[CODE_W-1:0] : dout[CODE_W-1:0];
    num = NUM_W'(dx[VAL_W-1:0]) * NUM_W'(mag);
  end

  mosc_div #(
    .NW(NUM_W),
    .DW(DEN_W)
  ) u_div (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .start_i(div_start),
    .num_i(num),
    .den_i(den),
    .done_o(div_done),
    .quot_o(quot)
  );

  // ----------------------------------------------------------------
  // Round-robin sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    seq_d = seq_q;
    idx_d = idx_q;
    code_d = code_q;
    active_d = active_q;
    div_start = 1'b0;
    unique case (seq_q)
      SEQ_EVAL:
      begin
        active_d[idx_q] = live;
        idx_d = idx_q + CH_W'(1);
        if (!live)
        begin
          code_d[idx_q] = '0;
        end
        else if (x <= in1)
        begin
          code_d[idx_q] = ch_out1[idx_q];
        end
        else if (x >= in2)
        begin
          code_d[idx_q] = ch_out2[idx_q];
        end
        else
        begin
          // Here in1 < x < in2, so the divisor is always positive
          div_start = 1'b1;
          idx_d = idx_q;
          seq_d = SEQ_DIV;
        end
      end
      SEQ_DIV:
      begin
        // Quotient is below mag, so the sum stays inside both points
        if (div_done)
        begin
          code_d[idx_q] = neg ? ch_out1[idx_q] - quot[CODE_W-1:0]
                              : ch_out1[idx_q] + quot[CODE_W-1:0];
          idx_d = idx_q + CH_W'(1);
          seq_d = SEQ_EVAL;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      seq_q <= SEQ_EVAL;
      idx_q <= '0;
      code_q <= '0;
      active_q <= '0;
    end
    else
    begin
      seq_q <= seq_d;
      idx_q <= idx_d;
      code_q <= code_d;
      active_q <= active_d;
    end
  end

  assign ma_code_o = code_q;
  assign ma_active_o = active_q;

endmodule : mosc_top

// >>> include/mosc_pkg.sv
/*
  Shared constants, register map, field layout and types for the
  milliampere output scaling control block.
  Assumes the includer compiles this package before every design file.
*/
package mosc_pkg;

  // ----------------------------------------------------------------
  // Structure
  // ----------------------------------------------------------------
  localparam int NUM_CARDS = 2;
  localparam int CH_PER_CARD = 4;
  localparam int NUM_CH = NUM_CARDS * CH_PER_CARD;
  localparam int NUM_PAIRS = NUM_CH / 2;
  localparam int CH_W = 3;
  localparam int NUM_CAT = 5;
  localparam int QTY_W = 2;
  localparam int QTY_PER_CAT = 4;
  localparam int NUM_SRC = NUM_CAT * QTY_PER_CAT;
  localparam int SEL_W = 5;

  // ----------------------------------------------------------------
  // Data widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int ADDR_W = 9;
  localparam int VAL_W = 36;
  localparam int CODE_W = 18;
  localparam int HI_W = VAL_W - DATA_W;
  localparam int NUM_W = 55;
  localparam int DEN_W = VAL_W + 1;

  // ----------------------------------------------------------------
  // Register map, byte addresses
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_PAIR_EN = 9'h000;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 9'h004;
  localparam int CH_SPACE_BIT = 8;
  localparam int CH_IDX_LSB = 5;
  localparam int REG_IDX_LSB = 2;
  localparam logic [2:0] ROFF_CFG = 3'h0;
  localparam logic [2:0] ROFF_IN1_LO = 3'h1;
  localparam logic [2:0] ROFF_IN1_HI = 3'h2;
  localparam logic [2:0] ROFF_OUT1 = 3'h3;
  localparam logic [2:0] ROFF_IN2_LO = 3'h4;
  localparam logic [2:0] ROFF_IN2_HI = 3'h5;
  localparam logic [2:0] ROFF_OUT2 = 3'h6;
  localparam logic [2:0] ROFF_NOW = 3'h7;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CFG_EN_BIT = 0;
  localparam int CFG_CAT_LSB = 4;
  localparam int CFG_QTY_LSB = 8;
  localparam int STAT_BUSY_BIT = 8;

  // ----------------------------------------------------------------
  // Reset values and limits (inputs in thousandths, outputs in 0.1 uA)
  // ----------------------------------------------------------------
  localparam logic [NUM_PAIRS-1:0] PAIR_EN_RST = 4'h0;
  localparam logic signed [VAL_W-1:0] IN1_RST = 36'sh0;
  localparam logic signed [VAL_W-1:0] IN2_RST = 36'sh3e8;
  localparam logic [CODE_W-1:0] OUT_RST = 18'h0;
  localparam logic signed [VAL_W-1:0] IN_MAX = 36'sh2540be400;
  localparam logic [CODE_W-1:0] OUT_MAX = 18'h3a980;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CAT_CURRENT,
    CAT_VOLTAGE,
    CAT_POWER,
    CAT_IMPEDANCE,
    CAT_OTHER
  } mosc_cat_t;

  typedef enum logic {
    SEQ_EVAL,
    SEQ_DIV
  } mosc_seq_t;

  // ----------------------------------------------------------------
  // Clamps
  // ----------------------------------------------------------------
  function automatic logic signed [VAL_W-1:0] mosc_sat_in(
    input logic signed [VAL_W-1:0] v
  );
    logic signed [VAL_W-1:0] r;
    r = v;
    if (v > IN_MAX)
    begin
      r = IN_MAX;
    end
    else if (v < -IN_MAX)
    begin
      r = -IN_MAX;
    end
    return r;
  endfunction : mosc_sat_in

  function automatic logic [CODE_W-1:0] mosc_sat_out(input logic [DATA_W-1:0] v);
    logic [CODE_W-1:0] r;
    r = v[CODE_W-1:0];
    if (v > DATA_W'(OUT_MAX))
    begin
      r = OUT_MAX;
    end
    return r;
  endfunction : mosc_sat_out

endpackage : mosc_pkg

// >>> src/mosc_div.sv
/*
  Unsigned restoring divider, one quotient bit per clock.
  Assumes the divisor is non-zero and held by the caller's logic only
  at start; operands are captured on start_i.
*/
`timescale 1ns/1ns
module mosc_div #(
  parameter int NW = 55,
  parameter int DW = 37
) (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic start_i,
  input wire logic [NW-1:0] num_i,
  input wire logic [DW-1:0] den_i,
  output logic done_o,
  output logic [NW-1:0] quot_o
);

  localparam int CW = $clog2(NW + 1);

  logic [NW-1:0] num_q, num_d;
  logic [NW-1:0] quot_q, quot_d;
  logic [DW-1:0] den_q, den_d;
  logic [DW:0] rem_q, rem_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic done_q, done_d;
  logic [DW:0] rem_sh;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    num_d = num_q;
    quot_d = quot_q;
    den_d = den_q;
    rem_d = rem_q;
    cnt_d = cnt_q;
    done_d = 1'b0;
    rem_sh = {rem_q[DW-1:0], num_q[NW-1]};
    if (start_i)
    begin
      num_d = num_i;
      den_d = den_i;
      rem_d = '0;
      quot_d = '0;
      cnt_d = CW'(NW);
    end
    else if (cnt_q != '0)
    begin
      num_d = {num_q[NW-2:0], 1'b0};
      // Remainder stays below the divisor, so one extra bit is enough
      if (rem_sh >= {1'b0, den_q})
      begin
        rem_d = rem_sh - {1'b0, den_q};
        quot_d = {quot_q[NW-2:0], 1'b1};
      end
      else
      begin
        rem_d = rem_sh;
        quot_d = {quot_q[NW-2:0], 1'b0};
      end
      cnt_d = cnt_q - CW'(1);
      done_d = (cnt_q == CW'(1));
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      num_q <= '0;
      quot_q <= '0;
      den_q <= '0;
      rem_q <= '0;
      cnt_q <= '0;
      done_q <= 1'b0;
    end
    else
    begin
      num_q <= num_d;
      quot_q <= quot_d;
      den_q <= den_d;
      rem_q <= rem_d;
      cnt_q <= cnt_d;
      done_q <= done_d;
    end
  end

  assign done_o = done_q;
  assign quot_o = quot_q;

endmodule : mosc_div

// >>> src/mosc_chan_cfg.sv
/*
  Settings of one output channel: enable, category, quantity and the
  two points of the scaling curve.
  Assumes wr_i is a single-cycle write strobe from the bus slave.
*/
`timescale 1ns/1ns
module mosc_chan_cfg
  import mosc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic wr_i,
  input wire logic [2:0] reg_i,
  input wire logic [DATA_W-1:0] wdata_i,
  output logic en_o,
  output logic [2:0] cat_o,
  output logic [QTY_W-1:0] qty_o,
  output logic signed [VAL_W-1:0] in1_o,
  output logic signed [VAL_W-1:0] in2_o,
  output logic [CODE_W-1:0] out1_o,
  output logic [CODE_W-1:0] out2_o
);

  logic en_q, en_d;
  mosc_cat_t cat_q, cat_d;
  logic [QTY_W-1:0] qty_q, qty_d;
  logic signed [VAL_W-1:0] in1_q, in1_d, in2_q, in2_d;
  logic [CODE_W-1:0] out1_q, out1_d, out2_q, out2_d;
  logic [2:0] wcat;

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  always_comb
  begin
    en_d = en_q;
    cat_d = cat_q;
    qty_d = qty_q;
    in1_d = in1_q;
    in2_d = in2_q;
    out1_d = out1_q;
    out2_d = out2_q;
    wcat = wdata_i[CFG_CAT_LSB +: 3];
    if (wr_i)
    begin
      unique case (reg_i)
        ROFF_CFG:
        begin
          en_d = wdata_i[CFG_EN_BIT];
          // Illegal category keeps the old selection pair intact
          if (wcat < 3'(NUM_CAT))
          begin
            cat_d = mosc_cat_t'(wcat);
            qty_d = wdata_i[CFG_QTY_LSB +: QTY_W];
          end
        end
        ROFF_IN1_LO: in1_d = {in1_q[VAL_W-1:DATA_W], wdata_i};
        ROFF_IN1_HI: in1_d = {wdata_i[HI_W-1:0], in1_q[DATA_W-1:0]};
        ROFF_OUT1: out1_d = mosc_sat_out(wdata_i);
        ROFF_IN2_LO: in2_d = {in2_q[VAL_W-1:DATA_W], wdata_i};
        ROFF_IN2_HI: in2_d = {wdata_i[HI_W-1:0], in2_q[DATA_W-1:0]};
        ROFF_OUT2: out2_d = mosc_sat_out(wdata_i);
        ROFF_NOW:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      en_q <= 1'b0;
      cat_q <= CAT_CURRENT;
      qty_q <= '0;
      in1_q <= IN1_RST;
      in2_q <= IN2_RST;
      out1_q <= OUT_RST;
      out2_q <= OUT_RST;
    end
    else
    begin
      en_q <= en_d;
      cat_q <= cat_d;
      qty_q <= qty_d;
      in1_q <= in1_d;
      in2_q <= in2_d;
      out1_q <= out1_d;
      out2_q <= out2_d;
    end
  end

  assign en_o = en_q;
  assign cat_o = cat_q;
  assign qty_o = qty_q;
  assign in1_o = in1_q;
  assign in2_o = in2_q;
  assign out1_o = out1_q;
  assign out2_o = out2_q;

endmodule : mosc_chan_cfg

// >>> sim/mosc_top_chk.sv
/*
  Port checker for mosc_top, bound into every instance.
  Assumes a bus master that holds each request until waitrequest is low.
*/
`timescale 1ns/1ns
module mosc_top_chk
  import mosc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [DATA_W-1:0] avs_writedata_i,
  input wire logic [DATA_W-1:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic [NUM_CH-1:0][CODE_W-1:0] ma_code_o,
  input wire logic [NUM_CH-1:0] ma_active_o
);
  // ----------------------------------------------------------------
  // Shadow of channel enables and write history
  // ----------------------------------------------------------------
  logic [NUM_CH-1:0] en_q;
  logic [NUM_CH-1:0] en_d;
  logic wr_seen_q;
  logic wr_seen_d;
  logic acc_rd;
  logic [CH_W-1:0] ch;
  logic hid_reg;
  logic over;
  logic idle_nz;

  always_comb
  begin
    acc_rd = avs_read_i & ~avs_waitrequest_o;
    ch = avs_address_i[CH_IDX_LSB +: CH_W];
    hid_reg = avs_address_i[CH_SPACE_BIT] && avs_address_i[4:2] != ROFF_CFG
      && avs_address_i[4:2] != ROFF_NOW;
    en_d = en_q;
    if (avs_write_i && !avs_waitrequest_o && avs_address_i[CH_SPACE_BIT]
      && avs_address_i[4:2] == ROFF_CFG)
      en_d[ch] = avs_writedata_i[CFG_EN_BIT];
    wr_seen_d = wr_seen_q | (avs_write_i & ~avs_waitrequest_o);
    over = 1'b0;
    idle_nz = 1'b0;
    for (int i = 0; i < NUM_CH; i++)
    begin
      over = over | (ma_code_o[i] > OUT_MAX);
      idle_nz = idle_nz | (!ma_active_o[i] && ma_code_o[i] != '0);
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      en_q <= '0;
      wr_seen_q <= 1'b0;
    end
    else
    begin
      en_q <= en_d;
      wr_seen_q <= wr_seen_d;
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  sequence s_req;
    avs_read_i || avs_write_i;
  endsequence
  sequence s_held;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence

  a_wait_first: assert property ($rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o)
    else $error("no wait cycle on new request");
  a_wait_once: assert property (s_held |=> s_req ##0 !avs_waitrequest_o)
    else $error("more than one wait cycle");
  a_wait_idle: assert property (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
    else $error("waitrequest without request");
  a_unmapped_zero: assert property (acc_rd && avs_address_i == 9'h0f0 |-> avs_readdata_o == '0)
    else $error("unmapped read not zero");
  a_code_range: assert property (!over)
    else $error("output code above full scale");
  a_idle_zero: assert property (!idle_nz)
    else $error("inactive channel drives current");
  a_quiet_reset: assert property (!wr_seen_q |-> ma_active_o == '0)
    else $error("channel active before any write");
  a_hidden_zero: assert property (acc_rd && hid_reg && !en_q[ch] |-> avs_readdata_o == '0)
    else $error("disabled channel setting visible");
endmodule : mosc_top_chk

bind mosc_top mosc_top_chk i_mosc_top_chk (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .ma_code_o(ma_code_o), .ma_active_o(ma_active_o));

// >>> sim/mosc_loop_drv.sv
/*
  Behavioural current-loop driver of both option cards.
  Assumes codes in 0.1 uA steps, registered on clk_sys_i.
*/
`timescale 1ns/1ns
module mosc_loop_drv
  import mosc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic [NUM_CH-1:0][CODE_W-1:0] code_i,
  input wire logic [NUM_CH-1:0] active_i,
  output logic [NUM_CH-1:0][CODE_W-1:0] loop_o,
  output logic fault_o
);
  // Card c drives channels 4c..4c+3
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      loop_o <= '0;
      fault_o <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        // Gated channel sinks no current
        loop_o[i] <= active_i[i] ? code_i[i] : '0;
        // Sticky, so a one-cycle glitch is not lost
        if (code_i[i] > OUT_MAX)
          fault_o <= 1'b1;
      end
    end
  end
endmodule : mosc_loop_drv

// >>> sim/mosc_top_test.sv
/*
  Self-checking bench for mosc_top with a current-loop driver model.
  Assumes mosc_pkg, mosc_top, mosc_loop_drv and the checker compiled first.
*/
`timescale 1ns/1ns
module mosc_top_test;
  import mosc_pkg::*;
  // ----------------------------------------------------------------
  // Signals and state
  // ----------------------------------------------------------------
  logic clk_sys_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [DATA_W-1:0] wdata = '0;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] rdata_q;
  logic waitreq;
  logic [NUM_SRC-1:0][VAL_W-1:0] meas = '0;
  logic [NUM_CH-1:0][CODE_W-1:0] code;
  logic [NUM_CH-1:0] active;
  logic [NUM_CH-1:0][CODE_W-1:0] loop;
  logic fault;
  logic [15:0] lfsr_q = 16'ha745;
  logic [NUM_CH-1:0] ch_en = '0;
  logic [NUM_PAIRS-1:0] pair_en = '0;
  longint in1 [NUM_CH];
  longint in2 [NUM_CH];
  longint o1 [NUM_CH];
  longint o2 [NUM_CH];
  longint xs [NUM_CH];
  int n_mismatch = 0;
  int total_checks = 0;

  always #50 clk_sys_i = ~clk_sys_i;

  mosc_top i_mosc_top (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_readdata_o(rdata),
    .avs_waitrequest_o(waitreq), .meas_val_i(meas), .ma_code_o(code), .ma_active_o(active));
  mosc_loop_drv i_mosc_loop_drv (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .code_i(code),
    .active_i(active), .loop_o(loop), .fault_o(fault));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic int rnd();
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    return int'(lfsr_q);
  endfunction : rnd

  function automatic logic [ADDR_W-1:0] cha(input int c, input logic [2:0] r);
    return ADDR_W'(32'h100 + c * 32 + int'(r) * 4);
  endfunction : cha

  function automatic logic [DATA_W-1:0] cfgw(input int c);
    return DATA_W'(((c % 4) << 8) | ((c % 5) << 4) | 1);
  endfunction : cfgw

  function automatic logic [63:0] exp_code(input int c, input longint x);
    if (!(ch_en[c] && pair_en[c / 2]))
      return '0;
    if (x <= in1[c])
      return o1[c];
    if (x >= in2[c])
      return o2[c];
    // Signed divide truncates toward zero, i.e. toward output one
    return o1[c] + (x - in1[c]) * (o2[c] - o1[c]) / (in2[c] - in1[c]);
  endfunction : exp_code

  function automatic logic [NUM_CH-1:0] exp_act();
    logic [NUM_CH-1:0] a;
    for (int c = 0; c < NUM_CH; c++)
      a[c] = ch_en[c] & pair_en[c / 2];
    return a;
  endfunction : exp_act

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  task automatic bus(input logic r, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    addr <= a;
    rd <= r;
    wr <= ~r;
    wdata <= d;
    do
    begin
      @(posedge clk_sys_i);
      n++;
    end
    while (waitreq !== 1'b0);
    // One wait cycle: the answer comes on the second edge
    chk("wait_edges", 64'd2, 64'(n));
    rdata_q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk_sys_i);
  endtask : bus

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] m,
    input logic [DATA_W-1:0] e);
    bus(1'b1, a, '0);
    chk("readdata", 64'(e), 64'(rdata_q & m));
  endtask : rd_chk

  task automatic wr36(input logic [ADDR_W-1:0] a, input logic [63:0] v);
    bus(1'b0, a, v[31:0]);
    bus(1'b0, a + 9'h004, {28'h0, v[35:32]});
  endtask : wr36

  task automatic tally_and_finish();
    if (n_mismatch == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_chk(OFF_PAIR_EN, 32'hf, 32'h0);
    rd_chk(cha(0, ROFF_CFG), 32'h3ff, 32'h0);
    rd_chk(cha(0, ROFF_IN2_LO), '1, 32'h0);
    bus(1'b0, cha(0, ROFF_CFG), 32'h1);
    rd_chk(cha(0, ROFF_IN1_HI), '1, 32'h0);
    rd_chk(cha(0, ROFF_IN2_LO), '1, 32'h3e8);
    rd_chk(cha(0, ROFF_OUT1), '1, 32'h0);
    rd_chk(9'h0f0, '1, 32'h0);
    bus(1'b0, OFF_STATUS, 32'hff);
    rd_chk(OFF_STATUS, 32'hff, 32'h0);
    for (int c = 0; c < NUM_CH; c++)
    begin
      ch_en[c] = 1'b1;
      in1[c] = -longint'(rnd()) * 100;
      in2[c] = in1[c] + 2 + longint'(rnd()) * 50;
      o1[c] = rnd() * 3;
      o2[c] = (c == 7) ? 240000 : rnd() * 3;
      bus(1'b0, cha(c, ROFF_CFG), cfgw(c));
      wr36(cha(c, ROFF_IN1_LO), in1[c]);
      wr36(cha(c, ROFF_IN2_LO), in2[c]);
      bus(1'b0, cha(c, ROFF_OUT1), 32'(o1[c]));
      bus(1'b0, cha(c, ROFF_OUT2), (c == 7) ? 32'h3ffff : 32'(o2[c]));
      rd_chk(cha(c, ROFF_CFG), 32'h3ff, cfgw(c));
      rd_chk(cha(c, ROFF_IN1_HI), '1, 32'(in1[c][35:32]));
    end
    rd_chk(cha(7, ROFF_OUT2), '1, 32'h3a980);
    bus(1'b0, cha(1, ROFF_CFG), 32'h351);
    rd_chk(cha(1, ROFF_CFG), 32'h3ff, 32'h111);
    for (int ph = 0; ph < 4; ph++)
    begin
      pair_en = (ph == 0) ? 4'h5 : (ph == 1) ? 4'ha : 4'hf;
      bus(1'b0, OFF_PAIR_EN, {28'h0, pair_en});
      if (ph == 3)
      begin
        ch_en[1] = 1'b0;
        bus(1'b0, cha(1, ROFF_CFG), 32'h110);
        rd_chk(cha(1, ROFF_OUT1), '1, 32'h0);
      end
      for (int c = 0; c < NUM_CH; c++)
      begin
        case (ph)
          0: xs[c] = in1[c] - rnd();
          1: xs[c] = in2[c];
          2: xs[c] = in1[c] + 1 + rnd() % (in2[c] - in1[c] - 1);
          default: xs[c] = in1[c];
        endcase
        meas[(c % 5) * 4 + c % 4] <= xs[c][VAL_W-1:0];
      end
      // Two full passes, so a division begun on stale inputs is redone
      repeat (1000) @(posedge clk_sys_i);
      chk("ma_active", 64'(exp_act()), 64'(active));
      for (int c = 0; c < NUM_CH; c++)
      begin
        chk("ma_code", exp_code(c, xs[c]), 64'(code[c]));
        chk("loop", exp_code(c, xs[c]), 64'(loop[c]));
      end
      rd_chk(OFF_STATUS, 32'hff, 32'(exp_act()));
      rd_chk(cha(ph, ROFF_NOW), '1, 32'(exp_code(ph, xs[ph])));
    end
    chk("fault", 64'h0, 64'(fault));
    // Reset in mid-run must bring every setting back to its default
    nrst_i <= 1'b0;
    @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    @(posedge clk_sys_i);
    chk("ma_active", 64'h0, 64'(active));
    rd_chk(OFF_PAIR_EN, 32'hf, 32'h0);
    rd_chk(cha(2, ROFF_CFG), 32'h3ff, 32'h0);
    tally_and_finish();
  end

  initial
  begin
    repeat (20000) @(posedge clk_sys_i);
    n_mismatch++;
    tally_and_finish();
  end
endmodule : mosc_top_test
